// ==== design/tca_core.sv ====
// Conversion scheduler, limit comparator and alert output of the temperature sensor.
// Assumes the serial engine and the converter run on clock_i; general call reset arrives as a pulse.
// Summary of operation
// - With low polarity, flag reads 1 until upper run, 0 until lower run.
// - In comparator mode the flag always matches the alert pin.
// - Rate field picks period: 4 s, 1 s, 250 ms default, 125 ms.
// - Temperature register changes only when a conversion finishes.
// - Conversion starts right after reset; standby between periodic conversions.
// - Setting sleep stops periodic conversions at once; registers stay reachable.
// - Sleep entry may be slow; master pairs a one-shot with sleep entry.
// - Clearing sleep resumes periodic conversion at the selected rate.
// - Latch mode bit: 0 comparator, 1 interrupt behaviour of alert.
// - Comparator: assert after N results at or above upper, release after N at or below lower.
// - Interrupt: assert after N results at or above upper, hold until any read.
// - In interrupt mode, setting sleep also releases the alert.
// - Interrupt mode alternates upper and lower crossings, each held until a read.
// - General call reset clears latch mode, back to comparator mode.
// - Polarity bit: 0 alert active low, 1 active high.
// - Fault field bits 12:11 give N of 1, 2, 3 or 4.
// - One-shot in sleep runs one conversion, reads 1 meanwhile, then sleeps.
// - Limits share temperature format; serial engine sends high byte first.
// - Temperatures are 12-bit two's complement in bits 15:4, low bits zero.
// - Lower limit resets to 75 C code, upper limit to 80 C code.
`timescale 1ns/1ps

module tca_core
    import tca_pkg::*;
#(
    parameter int unsigned PERIOD_00_CYC = TCA_RATE_00_MS * TCA_CYC_PER_MS,
    parameter int unsigned PERIOD_01_CYC = TCA_RATE_01_MS * TCA_CYC_PER_MS,
    parameter int unsigned PERIOD_10_CYC = TCA_RATE_10_MS * TCA_CYC_PER_MS,
    parameter int unsigned PERIOD_11_CYC = TCA_RATE_11_MS * TCA_CYC_PER_MS
)
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic [1:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        gc_reset_i,
    output logic             conv_req_o,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] conv_result_i,
    output logic             alert_o,
    output logic             alert_oe_o
);

    // ************************************************************
    // State
    // ************************************************************
    tca_cfg_s         cfg_r;
    tca_cfg_s         cfg_nxt;
    tca_state_e       state_r;
    tca_state_e       state_nxt;
    logic [11:0]      temp_r;
    logic [11:0]      low_r;
    logic [11:0]      high_r;
    logic [31:0]      period_ctr_r;
    logic [1:0]       fault_ctr_r;
    logic             over_r;
    logic             irq_r;
    logic [15:0]      rdata_r;

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic        wr_cfg     = wr_i && (addr_i == TCA_ADDR_CFG);
    wire logic        wr_low     = wr_i && (addr_i == TCA_ADDR_LOW);
    wire logic        wr_high    = wr_i && (addr_i == TCA_ADDR_HIGH);
    wire logic        wr_sleep   = wdata_i[TCA_CFG_SLEEP_BIT];
    wire logic        shot_req   = wr_cfg && wdata_i[TCA_CFG_SHOT_BIT] && (wr_sleep || cfg_r.sleep_select);
    wire logic        sleep_set  = wr_cfg && wr_sleep && !cfg_r.sleep_select;
    wire logic        conv_end   = (state_r == ST_CONV) && conv_done_i;
    wire logic [31:0] period_sel = (cfg_r.rate_select == 2'b00) ? 32'(PERIOD_00_CYC) :
                                   (cfg_r.rate_select == 2'b01) ? 32'(PERIOD_01_CYC) :
                                   (cfg_r.rate_select == 2'b10) ? 32'(PERIOD_10_CYC) :
                                                                  32'(PERIOD_11_CYC);
    wire logic        period_hit = period_ctr_r >= (period_sel - 32'h1);

    // ************************************************************
    // Limit compare and fault filter
    // ************************************************************
    wire logic        hit_high   = $signed(conv_result_i) >= $signed(high_r);
    wire logic        hit_low    = $signed(conv_result_i) <= $signed(low_r);
    wire logic        pending    = over_r ? hit_low : hit_high;
    wire logic        run_done   = conv_end && pending && (fault_ctr_r == cfg_r.fault_count_select);
    wire logic        active     = cfg_r.latch_mode_select ? irq_r : over_r;
    wire logic        pin_level  = cfg_r.active_level_select ? active : !active;
    wire logic        flag       = cfg_r.active_level_select ? over_r : !over_r;

    // ************************************************************
    // Configuration next value
    // ************************************************************
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_cfg)
        begin
            cfg_nxt.rate_select         = wdata_i[TCA_CFG_RATE_LSB +: 2];
            cfg_nxt.sleep_select        = wr_sleep;
            cfg_nxt.latch_mode_select   = wdata_i[TCA_CFG_LATCH_BIT];
            cfg_nxt.active_level_select = wdata_i[TCA_CFG_LEVEL_BIT];
            cfg_nxt.fault_count_select  = wdata_i[TCA_CFG_FAULT_LSB +: 2];
        end
        if (conv_end)
        begin
            cfg_nxt.one_shot = 1'b0;
        end
        if (shot_req)
        begin
            cfg_nxt.one_shot = 1'b1;
        end
        if (gc_reset_i)
        begin
            cfg_nxt.latch_mode_select = 1'b0;
        end
    end

    // ************************************************************
    // Conversion scheduler
    // ************************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY:
            begin
                if (cfg_r.sleep_select)
                begin
                    state_nxt = cfg_r.one_shot ? ST_CONV : ST_SLEEP;
                end
                else if (period_hit)
                begin
                    state_nxt = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_end)
                begin
                    state_nxt = cfg_r.sleep_select ? ST_SLEEP : ST_STANDBY;
                end
                else if (cfg_r.sleep_select && !cfg_r.one_shot)
                begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (!cfg_r.sleep_select || cfg_r.one_shot)
                begin
                    state_nxt = ST_CONV;
                end
            end
            default:
            begin
                state_nxt = ST_CONV;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cfg_r   <= '{one_shot: 1'b0, fault_count_select: 2'h0, active_level_select: 1'b0,
                         latch_mode_select: 1'b0, sleep_select: 1'b0, rate_select: TCA_RATE_RST};
            state_r <= ST_CONV;
        end
        else
        begin
            cfg_r   <= cfg_nxt;
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            low_r  <= TCA_LOW_RST;
            high_r <= TCA_HIGH_RST;
        end
        else
        begin
            low_r  <= wr_low ? wdata_i[15:TCA_TEMP_LSB] : low_r;
            high_r <= wr_high ? wdata_i[15:TCA_TEMP_LSB] : high_r;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            temp_r       <= TCA_TEMP_RST;
            period_ctr_r <= 32'h0;
        end
        else
        begin
            temp_r       <= conv_end ? conv_result_i : temp_r;
            period_ctr_r <= (state_nxt == ST_CONV && state_r != ST_CONV) ? 32'h0 :
                            (period_hit ? period_ctr_r : period_ctr_r + 32'h1);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            fault_ctr_r <= 2'h0;
            over_r      <= 1'b0;
        end
        else if (conv_end)
        begin
            fault_ctr_r <= (!pending || run_done) ? 2'h0 : fault_ctr_r + 2'h1;
            over_r      <= run_done ? !over_r : over_r;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            irq_r <= 1'b0;
        end
        else if (!cfg_r.latch_mode_select)
        begin
            irq_r <= 1'b0;
        end
        else if (run_done)
        begin
            irq_r <= 1'b1;
        end
        else if (rd_i || sleep_set)
        begin
            irq_r <= 1'b0;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    wire logic [15:0] cfg_word = {cfg_r.one_shot, 1'b1, 1'b0, cfg_r.fault_count_select,
                                  cfg_r.active_level_select, cfg_r.latch_mode_select, cfg_r.sleep_select,
                                  cfg_r.rate_select, flag, 5'h00};
    wire logic [15:0] rd_word  = (addr_i == TCA_ADDR_TEMP) ? {temp_r, 4'h0} :
                                 (addr_i == TCA_ADDR_CFG)  ? cfg_word :
                                 (addr_i == TCA_ADDR_LOW)  ? {low_r, 4'h0} :
                                                             {high_r, 4'h0};

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= rd_i ? rd_word : 16'h0000;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata_o    = rdata_r;
    assign conv_req_o = (state_r == ST_CONV);
    assign alert_o    = 1'b0;
    assign alert_oe_o = !pin_level;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_shot_end;
        cfg_r.one_shot && cfg_r.sleep_select && conv_end;
    endsequence

    sequence s_sleeping;
        (state_r == ST_SLEEP) && !conv_req_o;
    endsequence

    AST_FLAG_PIN: assert property (!cfg_r.latch_mode_select |-> flag == !alert_oe_o)
        else $error("Flag differs from alert pin in comparator mode");

    AST_TEMP_HOLD: assert property (!conv_end |=> $stable(temp_r))
        else $error("Temperature changed without a finished conversion");

    AST_START: assert property (disable iff (1'b0) srst_i ##1 !srst_i |-> conv_req_o)
        else $error("No conversion right after reset");

    AST_SLEEP_STOP: assert property (cfg_r.sleep_select && !cfg_r.one_shot && !shot_req && !wr_cfg
                                     |=> ##1 s_sleeping)
        else $error("Conversion continues in sleep");

    AST_WAKE: assert property ((state_r == ST_SLEEP) && !cfg_r.sleep_select |=> conv_req_o)
        else $error("No conversion after leaving sleep");

    AST_IRQ_HOLD: assert property (cfg_r.latch_mode_select && irq_r && !rd_i && !sleep_set && !gc_reset_i
                                   && !wr_cfg |=> irq_r)
        else $error("Interrupt output released without a read");

    AST_IRQ_SLEEP: assert property (cfg_r.latch_mode_select && sleep_set && !run_done |=> !irq_r)
        else $error("Sleep entry did not release the interrupt output");

    AST_GC_RESET: assert property (gc_reset_i |=> !cfg_r.latch_mode_select)
        else $error("General call reset left interrupt mode set");

    AST_SHOT: assert property (s_shot_end |=> s_sleeping and !cfg_r.one_shot)
        else $error("One-shot did not finish back in sleep");

    AST_FAULT_RESTART: assert property (conv_end && !pending |=> fault_ctr_r == 2'h0)
        else $error("Fault counter kept a broken run");

    AST_PERIOD_START: assert property ((state_r == ST_STANDBY) && !cfg_r.sleep_select
                                       && period_hit |=> conv_req_o)
        else $error("Periodic conversion did not start at the period end");

    AST_STANDBY_IDLE: assert property ((state_r == ST_STANDBY) && !cfg_r.sleep_select
                                       && !period_hit |=> !conv_req_o)
        else $error("Conversion started before the period ended");

    AST_PIN_LEVEL: assert property ((!alert_oe_o) ==
                                    ((cfg_r.latch_mode_select ? irq_r : over_r) ~^ cfg_r.active_level_select))
        else $error("Alert pin level does not follow the polarity bit");

    AST_SHOT_IGNORED: assert property (wr_cfg && !wr_sleep && !cfg_r.sleep_select && !cfg_r.one_shot
                                       |=> !cfg_r.one_shot)
        else $error("One-shot accepted outside sleep");

    AST_TEMP_LOAD: assert property (conv_end |=> temp_r == $past(conv_result_i))
        else $error("Finished conversion not stored");

    AST_LIMIT_WRITE: assert property (wr_high |=> {high_r, 4'h0} == ($past(wdata_i) & 16'hfff0))
        else $error("Upper limit write not stored");

    AST_OVER_HOLD: assert property (!conv_end |=> $stable(over_r))
        else $error("Limit state changed without a finished conversion");

endmodule : tca_core

// ==== pkg/tca_pkg.sv ====
// Constants, types and register map of the temperature conversion and alert control block.
// Assumes a single 100 MHz clock shared with the serial engine and the converter.
package tca_pkg;

    // ************************************************************
    // Register map and field positions
    // ************************************************************
    localparam logic [1:0] TCA_ADDR_TEMP      = 2'h0;
    localparam logic [1:0] TCA_ADDR_CFG       = 2'h1;
    localparam logic [1:0] TCA_ADDR_LOW       = 2'h2;
    localparam logic [1:0] TCA_ADDR_HIGH      = 2'h3;

    localparam int         TCA_TEMP_LSB       = 4;
    localparam int         TCA_CFG_FLAG_BIT   = 5;
    localparam int         TCA_CFG_RATE_LSB   = 6;
    localparam int         TCA_CFG_SLEEP_BIT  = 8;
    localparam int         TCA_CFG_LATCH_BIT  = 9;
    localparam int         TCA_CFG_LEVEL_BIT  = 10;
    localparam int         TCA_CFG_FAULT_LSB  = 11;
    localparam int         TCA_CFG_FIXED_BIT  = 14;
    localparam int         TCA_CFG_SHOT_BIT   = 15;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [1:0]  TCA_RATE_RST      = 2'h2;
    localparam logic [11:0] TCA_LOW_RST       = 12'h4b0;
    localparam logic [11:0] TCA_HIGH_RST      = 12'h500;
    localparam logic [11:0] TCA_TEMP_RST      = 12'h000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned TCA_CLK_HZ        = 100_000_000;
    localparam int unsigned TCA_CYC_PER_MS    = TCA_CLK_HZ / 1000;
    localparam int unsigned TCA_RATE_00_MS    = 4000;
    localparam int unsigned TCA_RATE_01_MS    = 1000;
    localparam int unsigned TCA_RATE_10_MS    = 250;
    localparam int unsigned TCA_RATE_11_MS    = 125;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       one_shot;
        logic [1:0] fault_count_select;
        logic       active_level_select;
        logic       latch_mode_select;
        logic       sleep_select;
        logic [1:0] rate_select;
    } tca_cfg_s;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_CONV    = 2'b01,
        ST_SLEEP   = 2'b10
    } tca_state_e;

endpackage : tca_pkg

// ==== sim/tca_conv_model.sv ====
// Behavioural converter standing at the far side of the alert control core.
// Assumes the core raises conv_req_i for one conversion and samples the done pulse on clock_i.
`timescale 1ns/1ps

module tca_conv_model
#(
    parameter int unsigned LATENCY = 8
)
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        conv_req_i,
    input  wire logic [11:0] value_i,
    output logic             conv_done_o,
    output logic      [11:0] conv_result_o
);
    // ************************************************************
    // Conversion timing; result bus scrambled outside the done cycle
    // ************************************************************
    int unsigned cnt_r;

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            cnt_r         <= 0;
            conv_done_o   <= 1'b0;
            conv_result_o <= 12'ha5a;
        end
        else if (conv_req_i && !conv_done_o && cnt_r == LATENCY - 1)
        begin
            cnt_r         <= 0;
            conv_done_o   <= 1'b1;
            conv_result_o <= value_i;
        end
        else
        begin
            cnt_r         <= (conv_req_i && !conv_done_o) ? cnt_r + 1 : 0;
            conv_done_o   <= 1'b0;
            conv_result_o <= ~conv_result_o;
        end
    end
endmodule : tca_conv_model

// ==== sim/tca_core_tb.sv ====
// Self-checking bench of the alert control core: registers, rates, sleep, one-shot, alert modes.
// Assumes tca_pkg and the converter model are compiled first; 100 MHz clock.
`timescale 1ns/1ps

module tca_core_tb;
    import tca_pkg::*;
    localparam int          P00 = 40;
    localparam int          P01 = 30;
    localparam int          P10 = 20;
    localparam int          P11 = 10;
    localparam logic [11:0] HI  = 12'h190;
    localparam logic [11:0] LO  = 12'hd80;
    localparam logic [11:0] MID = 12'h000;

    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [1:0]  addr_i = 2'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        gc_reset_i = 1'b0;
    logic [11:0] conv_value = 12'h000;
    logic [15:0] rdata_o;
    logic        conv_req_o;
    logic        conv_done_i;
    logic [11:0] conv_result_i;
    logic        alert_o;
    logic        alert_oe_o;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          ref_cnt = 0;
    logic        ref_over = 1'b0;
    logic        ref_lat = 1'b0;
    logic        cur_lvl = 1'b0;
    logic        cur_latch = 1'b0;
    logic [1:0]  cur_fault = 2'h0;

    always #5 clock_i = ~clock_i;

    tca_core #(.PERIOD_00_CYC(P00), .PERIOD_01_CYC(P01), .PERIOD_10_CYC(P10), .PERIOD_11_CYC(P11)) u_tca_core (
        .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .gc_reset_i(gc_reset_i), .conv_req_o(conv_req_o), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o));

    tca_conv_model #(.LATENCY(8)) u_tca_conv_model (
        .clock_i(clock_i), .srst_i(srst_i), .conv_req_i(conv_req_o), .value_i(conv_value),
        .conv_done_o(conv_done_i), .conv_result_o(conv_result_i));

    // ************************************************************
    // Bus access, comparison and reference tasks
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [1:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        ref_lat = 1'b0;
        check(rdata_o, exp);
    endtask : rchk

    function automatic logic [15:0] cfg(input logic sh, input logic sm, input logic [1:0] r);
        return {sh, 2'h0, cur_fault, cur_lvl, cur_latch, sm, r, 6'h00};
    endfunction : cfg

    function automatic logic [15:0] cfg_rd(input logic sm);
        return cfg(1'b0, sm, 2'h3) | 16'h4000 | {10'h000, ref_over ~^ cur_lvl, 5'h00};
    endfunction : cfg_rd

    task automatic pin_chk();
        check({15'h0000, !alert_oe_o}, {15'h0000, (cur_latch ? ref_lat : ref_over) ~^ cur_lvl});
        check({15'h0000, alert_o}, 16'h0000);
    endtask : pin_chk

    task automatic wait_done();
        int   k;
        logic c;
        k = 0;
        do
        begin
            @(negedge clock_i);
            k++;
        end
        while (conv_done_i !== 1'b1 && k < 40);
        if (conv_done_i !== 1'b1)
        begin
            miscompares++;
        end
        c = ref_over ? ($signed(conv_value) <= $signed(LO)) : ($signed(conv_value) >= $signed(HI));
        ref_cnt = c ? ref_cnt + 1 : 0;
        if (ref_cnt == int'(cur_fault) + 1)
        begin
            ref_over = !ref_over;
            ref_cnt = 0;
            ref_lat = cur_latch;
        end
        @(negedge clock_i);
    endtask : wait_done

    task automatic shot(input logic [11:0] r);
        logic [15:0] d;
        conv_value <= r;
        wr(TCA_ADDR_CFG, cfg(1'b1, 1'b1, 2'h3));
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= TCA_ADDR_CFG;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        d = rdata_o;
        check({15'h0000, d[15]}, 16'h0001);
        wait_done();
        check({15'h0000, conv_req_o}, 16'h0000);
        pin_chk();
        rchk(TCA_ADDR_CFG, cfg_rd(1'b1));
        pin_chk();
        rchk(TCA_ADDR_TEMP, {r, 4'h0});
    endtask : shot

    task automatic gap(output int n);
        n = 0;
        while (conv_req_o === 1'b1 && n < 200)
        begin
            @(negedge clock_i);
            n++;
        end
        while (conv_req_o !== 1'b1 && n < 200)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 200)
        begin
            miscompares++;
        end
    endtask : gap

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // ************************************************************
    // Test sequence and watchdog
    // ************************************************************
    initial
    begin
        #200000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        int n;
        int per [4];
        per = '{P00, P01, P10, P11};
        repeat (12) @(posedge clock_i);
        srst_i <= 1'b0;
        @(negedge clock_i);
        check({15'h0000, conv_req_o}, 16'h0001);
        rchk(TCA_ADDR_TEMP, 16'h0000);
        rchk(TCA_ADDR_CFG, 16'h40a0);
        rchk(TCA_ADDR_LOW, 16'h4b00);
        rchk(TCA_ADDR_HIGH, 16'h5000);
        wr(TCA_ADDR_HIGH, 16'h019f);
        wr(TCA_ADDR_LOW, 16'hd80a);
        wr(TCA_ADDR_TEMP, 16'h7770);
        rchk(TCA_ADDR_HIGH, 16'h0190);
        rchk(TCA_ADDR_LOW, 16'hd800);
        rchk(TCA_ADDR_TEMP, 16'h0000);
        $display("test reset and registers done");
        for (int r = 0; r < 4; r++)
        begin
            wr(TCA_ADDR_CFG, cfg(1'b0, 1'b0, r[1:0]));
            repeat (3) gap(n);
            check(n[15:0], per[r][15:0]);
        end
        $display("test rates done");
        wr(TCA_ADDR_CFG, cfg(1'b0, 1'b1, 2'h3));
        @(posedge clock_i);
        repeat (30)
        begin
            @(negedge clock_i);
            check({15'h0000, conv_req_o}, 16'h0000);
        end
        rchk(TCA_ADDR_CFG, cfg_rd(1'b1));
        $display("test sleep done");
        for (int f = 0; f < 4; f++)
        begin
            cur_fault = f[1:0];
            cur_lvl = f[0];
            shot(MID);
            repeat (f) shot(HI);
            shot(MID);
            repeat (f + 1) shot(HI);
            repeat (f + 1) shot(LO);
        end
        $display("test comparator done");
        cur_fault = 2'h0;
        cur_lvl = 1'b0;
        cur_latch = 1'b1;
        shot(HI);
        shot(HI);
        shot(LO);
        shot(MID);
        shot(HI);
        conv_value <= LO;
        wr(TCA_ADDR_CFG, cfg(1'b0, 1'b0, 2'h3));
        @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, conv_req_o}, 16'h0001);
        wait_done();
        pin_chk();
        wr(TCA_ADDR_CFG, cfg(1'b0, 1'b1, 2'h3));
        ref_lat = 1'b0;
        @(posedge clock_i);
        @(negedge clock_i);
        pin_chk();
        check({15'h0000, conv_req_o}, 16'h0000);
        $display("test interrupt done");
        @(posedge clock_i);
        gc_reset_i <= 1'b1;
        @(posedge clock_i);
        gc_reset_i <= 1'b0;
        cur_latch = 1'b0;
        rchk(TCA_ADDR_CFG, cfg_rd(1'b1));
        pin_chk();
        $display("test general call reset done");
        print_verdict();
    end
endmodule : tca_core_tb
